// file: sim/ddac_bus_master.sv
// partner model: two-wire bus master that makes the clock and data
`timescale 1ns/10ps
`default_nettype none
module ddac_bus_master (
  input wire logic ref_clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_pull
);
  // long low phase so the slave's filter lag clears before clock high
  localparam int LOW_CYC = 6;
  localparam int HIGH_CYC = 2;
  // both lines idle high, data only pulled low or released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // one bit per clock, data moved only while clock is low
  task automatic put_bit(input logic b);
    wait_cyc(1);
    sda_pull = ~b;
    wait_cyc(LOW_CYC - 1);
    scl = 1'b1;
    wait_cyc(HIGH_CYC);
    scl = 1'b0;
  endtask
  // released line reads the pull-up unless the slave pulls it
  task automatic get_bit(output logic b);
    wait_cyc(1);
    sda_pull = 1'b0;
    wait_cyc(LOW_CYC - 1);
    scl = 1'b1;
    wait_cyc(1);
    b = sda_wire;
    wait_cyc(HIGH_CYC - 1);
    scl = 1'b0;
  endtask
  // start or repeated start, clock held high apart from any stop
  task automatic start_cond();
    wait_cyc(1);
    sda_pull = 1'b0;
    wait_cyc(LOW_CYC);
    scl = 1'b1;
    wait_cyc(4);
    sda_pull = 1'b1;
    wait_cyc(4);
    scl = 1'b0;
  endtask
  task automatic stop_cond();
    wait_cyc(1);
    sda_pull = 1'b1;
    wait_cyc(LOW_CYC);
    scl = 1'b1;
    wait_cyc(4);
    sda_pull = 1'b0;
    wait_cyc(8);
  endtask
  // eight bits then one acknowledge clock
  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(v[i]);
    get_bit(b);
    ack = ~b;
  endtask
  // not-acknowledge after the last byte of a read
  task automatic get_byte(input logic last, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) get_bit(v[i]);
    put_bit(last);
  endtask
endmodule
`default_nettype wire

// file: sim/testbench.sv
// testbench: converter slave driven by the bus master model
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import ddac_pkg::*;
  localparam logic [5:0] AHI = DDAC_ADDR_HI_DEF;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic addr_sel = 1'b1;
  logic scl, sda_pull, sda_out, sda_oe, sda_wire, buf_a, buf_b, rd_b;
  logic [11:0] out_a, out_b, in_a, in_b, ea, eb, ia, ib;
  logic [1:0] pd_a, pd_b, pa, pb;
  logic [53:0] act;
  logic [53:0] base = {24'h0, 2'h3, 2'h3, 2'h0, 24'h0};
  logic [53:0] notes[$];
  logic [3:0] cmds[7] = '{DDAC_CMD_IN_A, DDAC_CMD_IN_B, DDAC_CMD_XFER_A,
    DDAC_CMD_LOAD_A, DDAC_CMD_LOAD_B, DDAC_CMD_IN_B, DDAC_CMD_XFER_B};
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  always #20 ref_clk = ~ref_clk;
  // wired-and of both pull-downs against the pull-up
  assign sda_wire = ~(sda_pull | (sda_oe & ~sda_out));
  assign act = {out_a, out_b, pd_a, pd_b, buf_a, buf_b, in_a, in_b};
  // one-bit filter keeps the 2-cycle clock high phase of the 320 ns bus clock
  ddac_serial_slave #(.FILT_W(1)) uut (.ref_clk(ref_clk), .srst(srst),
    .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_sel(addr_sel), .channel_a_analog_out(out_a),
    .channel_b_analog_out(out_b), .powerdown_sel_a(pd_a),
    .powerdown_sel_b(pd_b), .buf_en_a(buf_a), .buf_en_b(buf_b),
    .input_reg_a(in_a), .input_reg_b(in_b));
  ddac_bus_master mdl (.ref_clk(ref_clk), .sda_wire(sda_wire), .scl(scl),
    .sda_pull(sda_pull));
  task automatic complete_run();
    if (errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [53:0] got, input logic [53:0] exp,
    input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got,
        exp);
    end
  endtask
  function automatic logic [53:0] snap_exp();
    return {ea, eb, pa, pb, pa == DDAC_PD_UP, pb == DDAC_PD_UP, ia, ib};
  endfunction
  // waits a few cycles after a change so a split commit reads whole
  always begin
    @(posedge ref_clk);
    if (!srst && act !== base) begin
      repeat (3) @(posedge ref_clk);
      if (notes.size() == 0) check(act, base, "unexpected update");
      else check(act, notes.pop_front(), "register update");
      base = act;
    end
  end
  // hang guard, far above the few thousand cycles the run needs
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      complete_run();
    end
  end
  task automatic frame_open(input logic rw, input logic [6:0] adr,
    input logic exp_ack);
    logic ack;
    mdl.start_cond();
    mdl.put_byte({adr, rw}, ack);
    check(ack, exp_ack, "address ack");
  endtask
  // one command word; the note is queued before the commit edge
  task automatic wr_word(input logic [3:0] cmd, input logic [11:0] d);
    logic k1, k2;
    mdl.put_byte({cmd, d[11:8]}, k1);
    mdl.put_byte(d[7:0], k2);
    check(k1 & k2, 1'b1, "data ack");
    rd_b = cmd[0];
    if (cmd == DDAC_CMD_IN_A || cmd == DDAC_CMD_LOAD_A || cmd[3:2] == 2'h3)
      ia = d;
    if (cmd == DDAC_CMD_IN_B || cmd == DDAC_CMD_LOAD_B || cmd[3:2] == 2'h3)
      ib = d;
    if (cmd[3] || cmd[2:1] == 2'h0) begin
      ea = ia;
      eb = ib;
    end
    notes.push_back(snap_exp());
  endtask
  task automatic wr_pd(input logic [1:0] mode, input logic [1:0] sel);
    logic k1, k2;
    mdl.put_byte({DDAC_CMD_EXT, DDAC_EXT_KEY}, k1);
    mdl.put_byte({4'h0, mode, sel}, k2);
    check(k1 & k2, 1'b1, "power ack");
    if (sel[0]) pa = mode;
    if (sel[1]) pb = mode;
    notes.push_back(snap_exp());
  endtask
  task automatic rd_check();
    logic [7:0] hi, lo;
    frame_open(1'b1, {AHI, addr_sel}, 1'b1);
    mdl.get_byte(1'b0, hi);
    mdl.get_byte(1'b1, lo);
    check({hi, lo}, {4'h0, rd_b ? eb : ea}, "read back");
    mdl.stop_cond();
  endtask
  initial begin
    logic ack;
    logic [11:0] r;
    {ea, eb, ia, ib} = '0;
    {pa, pb} = 4'hF;
    rd_b = 1'b0;
    r = 12'($urandom(23954));
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    srst = 1'b0;
    check(act, base, "reset state");
    repeat (10) @(negedge ref_clk);
    frame_open(1'b0, {AHI, 1'b1}, 1'b1);
    wr_pd(DDAC_PD_UP, 2'h3);
    // word commands back to back, one repeated start among them
    foreach (cmds[i]) begin
      r = (i == 3) ? 12'hFFF : 12'($urandom);
      if (cmds[i] == DDAC_CMD_XFER_A) r = ia;
      if (cmds[i] == DDAC_CMD_XFER_B) r = ib;
      if (i == 4) frame_open(1'b0, {AHI, 1'b1}, 1'b1);
      wr_word(cmds[i], r);
    end
    rd_check();
    frame_open(1'b0, {AHI, 1'b1}, 1'b1);
    wr_word(DDAC_CMD_ALL, 12'($urandom));
    for (int m = 1; m < 4; m++) wr_pd(2'(m), 2'h1);
    wr_pd(DDAC_PD_1K, 2'h2);
    wr_pd(DDAC_PD_UP, 2'h3);
    wr_word(DDAC_CMD_IN_A, 12'($urandom));
    rd_check();
    // wrong low address bit, then a byte the gated slave must ignore
    frame_open(1'b0, {AHI, 1'b0}, 1'b0);
    mdl.put_byte(8'h00, ack);
    check(ack, 1'b0, "gated after mismatch");
    mdl.stop_cond();
    frame_open(1'b0, 7'h00, 1'b0);
    mdl.stop_cond();
    addr_sel = 1'b0;
    repeat (10) @(negedge ref_clk);
    // stop in mid word leaves every register alone
    frame_open(1'b0, {AHI, 1'b0}, 1'b1);
    mdl.put_byte({DDAC_CMD_ALL, 4'h5}, ack);
    repeat (4) mdl.put_bit(1'b0);
    mdl.stop_cond();
    repeat (40) @(negedge ref_clk);
    check(notes.size(), 0, "updates missing");
    complete_run();
  end
endmodule
`default_nettype wire

// file: src/ddac_bus_if.sv
// interface: conditioned bus events from front end to protocol engine
`timescale 1ns/10ps
`default_nettype none
interface ddac_bus_if;
  logic scl_rise;
  logic scl_fall;
  logic sda_lvl;
  logic start_det;
  logic stop_det;
  modport front (output scl_rise, output scl_fall, output sda_lvl,
    output start_det, output stop_det);
  modport core (input scl_rise, input scl_fall, input sda_lvl,
    input start_det, input stop_det);
endinterface
`default_nettype wire

// file: src/ddac_line_front.sv
// front end: synchronise, deglitch and find edges on the two bus lines
`timescale 1ns/10ps
`default_nettype none
module ddac_line_front
  import ddac_pkg::*;
#(
  parameter int FILT_W = 2
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  ddac_bus_if.front ev
);
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] flt;
    logic [FILT_W-1:0] cnt_c;
    logic [FILT_W-1:0] cnt_d;
    logic [1:0] prev;
  } ddac_front_t;
  ddac_front_t st_ff, nxt_st;

  // s1 is read only by s2; filter counts agreement before accepting a level
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = {scl_in, sda_in};
    nxt_st.s2 = st_ff.s1;
    nxt_st.prev = st_ff.flt;
    if (st_ff.s2[1] == st_ff.flt[1]) begin
      nxt_st.cnt_c = '0;
    end else if (&st_ff.cnt_c) begin
      nxt_st.flt[1] = st_ff.s2[1];
      nxt_st.cnt_c = '0;
    end else begin
      nxt_st.cnt_c = st_ff.cnt_c + 1'b1;
    end
    if (st_ff.s2[0] == st_ff.flt[0]) begin
      nxt_st.cnt_d = '0;
    end else if (&st_ff.cnt_d) begin
      nxt_st.flt[0] = st_ff.s2[0];
      nxt_st.cnt_d = '0;
    end else begin
      nxt_st.cnt_d = st_ff.cnt_d + 1'b1;
    end
  end

  // idle bus is high on both lines
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_ff <= '{s1: 2'h3, s2: 2'h3, flt: 2'h3, cnt_c: '0, cnt_d: '0,
        prev: 2'h3};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // events from the filtered levels
  assign ev.scl_rise = st_ff.flt[1] & ~st_ff.prev[1];
  assign ev.scl_fall = ~st_ff.flt[1] & st_ff.prev[1];
  assign ev.sda_lvl = st_ff.flt[0];
  assign ev.start_det = st_ff.flt[1] & st_ff.prev[1] & st_ff.prev[0] &
    ~st_ff.flt[0];
  assign ev.stop_det = st_ff.flt[1] & st_ff.prev[1] & ~st_ff.prev[0] &
    st_ff.flt[0];

  a_start_stop_excl: assert property (@(posedge ref_clk) disable iff (srst)
    !(ev.start_det && ev.stop_det)) else $error("start and stop together");
  a_edge_needs_lvl: assert property (@(posedge ref_clk) disable iff (srst)
    ev.scl_rise |-> st_ff.flt[1]) else $error("clock rise without high");
endmodule
`default_nettype wire

// file: src/ddac_pkg.sv
// package: constants and types for the dual converter serial slave
package ddac_pkg;
  localparam int DDAC_CODE_W = 12;
  localparam logic [11:0] DDAC_CODE_ZERO = 12'h000;
  localparam logic [5:0] DDAC_ADDR_HI_DEF = 6'h1C;
  localparam logic [1:0] DDAC_PD_UP = 2'h0;
  localparam logic [1:0] DDAC_PD_FLOAT = 2'h1;
  localparam logic [1:0] DDAC_PD_1K = 2'h2;
  localparam logic [1:0] DDAC_PD_100K = 2'h3;
  localparam logic [3:0] DDAC_BIT_LAST = 4'h7;
  localparam logic [3:0] DDAC_BIT_ACK = 4'h8;
  localparam logic [3:0] DDAC_CMD_LOAD_A = 4'h0;
  localparam logic [3:0] DDAC_CMD_LOAD_B = 4'h1;
  localparam logic [3:0] DDAC_CMD_IN_A = 4'h4;
  localparam logic [3:0] DDAC_CMD_IN_B = 4'h5;
  localparam logic [3:0] DDAC_CMD_XFER_A = 4'h8;
  localparam logic [3:0] DDAC_CMD_XFER_B = 4'h9;
  localparam logic [3:0] DDAC_CMD_ALL = 4'hC;
  localparam logic [3:0] DDAC_CMD_EXT = 4'hF;
  localparam logic [3:0] DDAC_EXT_KEY = 4'h0;
  localparam int DDAC_EXT_PD_LO = 2;
  localparam int DDAC_EXT_SEL_A = 0;
  localparam int DDAC_EXT_SEL_B = 1;
  typedef enum {DDAC_IDLE, DDAC_ADDR, DDAC_ADDR_ACK, DDAC_WR, DDAC_WR_ACK,
    DDAC_RD, DDAC_RD_ACK, DDAC_GATED} ddac_state_t;
endpackage

// file: src/ddac_serial_slave.sv
// top: two-wire slave with dual channel registers and power-down control
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - address select pin sets the slave address low bit.
// - decode address and command, steer data to input or output registers.
// - output register writes change output now; input-only writes do not.
// - registers hold contents always, including in every power-down mode.
// - channel codes are unsigned straight binary, 0 through 4095.
// - reset clears output registers and enters 100k power-down.
// - every power-down mode disables buffers and disconnects the strings.
// - power bits 00 up, 01 float, 10 1k, 11 100k termination.
// - leaving power-down restores the previous output value.
// - slave only; never drives the clock; master makes the clock.
// - every byte is 8 bits followed by one acknowledge pulse.
// - data line is open drain: pull low or release.
// - one bit per clock; data stable while clock high; idle high.
// - start is data falling with clock high; stop is data rising.
// - after stop or address mismatch, ignore the clock until next start.
// - stop honoured anywhere, even in the same high pulse as a start.
// - back-to-back writes accepted with or without repeated start.
// - acknowledge matching address and data bytes in the ninth clock.
// - last address bit is direction: 0 write, 1 read.
// - commit on the falling clock in acknowledge; aborted writes change nothing.
// - general call ignored; only 7-bit addressing.
module ddac_serial_slave
  import ddac_pkg::*;
#(
  parameter logic [5:0] ADDR_HI = DDAC_ADDR_HI_DEF,
  parameter int FILT_W = 2
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_sel,
  output logic [11:0] channel_a_analog_out,
  output logic [11:0] channel_b_analog_out,
  output logic [1:0] powerdown_sel_a,
  output logic [1:0] powerdown_sel_b,
  output logic buf_en_a,
  output logic buf_en_b,
  output logic [11:0] input_reg_a,
  output logic [11:0] input_reg_b
);
  typedef struct packed {
    logic [1:0] ads;
    ddac_state_t fsm;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic rd;
    logic [1:0] bytes;
    logic [7:0] cmd_hi;
    logic ext;
    logic commit;
    logic drv_low;
    logic ack_ok;
    logic [11:0] in_a;
    logic [11:0] in_b;
    logic [11:0] out_a;
    logic [11:0] out_b;
    logic [1:0] pd_a;
    logic [1:0] pd_b;
  } ddac_core_t;
  ddac_core_t st_ff, nxt_st;
  ddac_bus_if bus ();

  ddac_line_front #(.FILT_W(FILT_W)) u_front (
    .ref_clk(ref_clk),
    .srst(srst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ev(bus.front)
  );

  // channel select from the low command bit
  function automatic logic cmd_is_b(input logic [3:0] c);
    return c[0];
  endfunction

  logic [6:0] my_addr;
  logic [7:0] rx_byte;
  logic [11:0] rx_code;
  assign my_addr = {ADDR_HI, st_ff.ads[1]};
  assign rx_byte = {st_ff.shreg[6:0], bus.sda_lvl};
  assign rx_code = {st_ff.cmd_hi[3:0], st_ff.shreg};

  // protocol engine: bits sampled on clock rise, data moved on clock fall
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ads = {st_ff.ads[0], addr_sel};
    nxt_st.commit = 1'b0;
    if (bus.stop_det) begin
      nxt_st.fsm = DDAC_GATED;
      nxt_st.drv_low = 1'b0;
    end else if (bus.start_det) begin
      nxt_st.fsm = DDAC_ADDR;
      nxt_st.bitn = '0;
      nxt_st.drv_low = 1'b0;
      nxt_st.bytes = '0;
    end else begin
      case (st_ff.fsm)
        DDAC_IDLE, DDAC_GATED: begin
          nxt_st.drv_low = 1'b0;
        end
        DDAC_ADDR, DDAC_WR: begin
          if (bus.scl_rise) begin
            nxt_st.shreg = rx_byte;
            nxt_st.bitn = st_ff.bitn + 4'h1;
          end else if (bus.scl_fall && st_ff.bitn == DDAC_BIT_ACK) begin
            nxt_st.bitn = '0;
            if (st_ff.fsm == DDAC_ADDR) begin
              // general call never matches the 7-bit compare
              if (st_ff.shreg[7:1] == my_addr) begin
                nxt_st.fsm = DDAC_ADDR_ACK;
                nxt_st.drv_low = 1'b1;
                nxt_st.rd = st_ff.shreg[0];
              end else begin
                nxt_st.fsm = DDAC_GATED;
              end
            end else begin
              nxt_st.fsm = DDAC_WR_ACK;
              nxt_st.drv_low = 1'b1;
            end
          end
        end
        DDAC_ADDR_ACK, DDAC_WR_ACK: begin
          if (bus.scl_fall) begin
            nxt_st.drv_low = 1'b0;
            if (st_ff.fsm == DDAC_WR_ACK) begin
              nxt_st.fsm = DDAC_WR;
              if (st_ff.bytes == 2'h0) begin
                nxt_st.cmd_hi = st_ff.shreg;
                nxt_st.bytes = 2'h1;
                nxt_st.ext = 1'b0;
              end else begin
                nxt_st.commit = 1'b1;
                nxt_st.bytes = 2'h0;
              end
            end else if (st_ff.rd) begin
              nxt_st.fsm = DDAC_RD;
              nxt_st.shreg = {4'h0, cmd_is_b(st_ff.cmd_hi[7:4]) ?
                st_ff.out_b[11:8] : st_ff.out_a[11:8]};
              nxt_st.drv_low = ~nxt_st.shreg[7];
              nxt_st.bytes = 2'h0;
            end else begin
              nxt_st.fsm = DDAC_WR;
              nxt_st.bytes = 2'h0;
            end
          end
        end
        DDAC_RD: begin
          if (bus.scl_fall) begin
            if (st_ff.bitn == DDAC_BIT_LAST) begin
              nxt_st.bitn = DDAC_BIT_ACK;
              nxt_st.drv_low = 1'b0;
              nxt_st.fsm = DDAC_RD_ACK;
            end else begin
              nxt_st.bitn = st_ff.bitn + 4'h1;
              nxt_st.shreg = {st_ff.shreg[6:0], 1'b0};
              nxt_st.drv_low = ~st_ff.shreg[6];
            end
          end
        end
        DDAC_RD_ACK: begin
          if (bus.scl_rise) begin
            nxt_st.rd = ~bus.sda_lvl; // master ack keeps the read going
          end else if (bus.scl_fall) begin
            nxt_st.bitn = '0;
            if (st_ff.rd && st_ff.bytes == 2'h0) begin
              nxt_st.fsm = DDAC_RD;
              nxt_st.bytes = 2'h1;
              nxt_st.shreg = cmd_is_b(st_ff.cmd_hi[7:4]) ? st_ff.out_b[7:0] :
                st_ff.out_a[7:0];
              nxt_st.drv_low = ~nxt_st.shreg[7];
            end else begin
              nxt_st.fsm = DDAC_GATED;
            end
          end
        end
        default: nxt_st.fsm = DDAC_GATED;
      endcase
    end
    // register update only on a completed data word
    if (st_ff.commit) begin
      case (st_ff.cmd_hi[7:4])
        DDAC_CMD_LOAD_A: begin
          nxt_st.in_a = rx_code;
          nxt_st.out_a = rx_code;
          nxt_st.out_b = st_ff.in_b;
        end
        DDAC_CMD_LOAD_B: begin
          nxt_st.in_b = rx_code;
          nxt_st.out_b = rx_code;
          nxt_st.out_a = st_ff.in_a;
        end
        DDAC_CMD_IN_A: nxt_st.in_a = rx_code;
        DDAC_CMD_IN_B: nxt_st.in_b = rx_code;
        DDAC_CMD_XFER_A, DDAC_CMD_XFER_B: begin
          nxt_st.out_a = cmd_is_b(st_ff.cmd_hi[7:4]) ? st_ff.in_a : rx_code;
          nxt_st.out_b = cmd_is_b(st_ff.cmd_hi[7:4]) ? rx_code : st_ff.in_b;
          if (cmd_is_b(st_ff.cmd_hi[7:4])) begin
            nxt_st.in_b = rx_code;
          end else begin
            nxt_st.in_a = rx_code;
          end
        end
        DDAC_CMD_ALL: begin
          nxt_st.in_a = rx_code;
          nxt_st.in_b = rx_code;
          nxt_st.out_a = rx_code;
          nxt_st.out_b = rx_code;
        end
        DDAC_CMD_EXT: begin
          if (st_ff.cmd_hi[3:0] == DDAC_EXT_KEY) begin
            // power bits only; code registers stay untouched
            if (st_ff.shreg[DDAC_EXT_SEL_A]) begin
              nxt_st.pd_a = st_ff.shreg[DDAC_EXT_PD_LO +: 2];
            end
            if (st_ff.shreg[DDAC_EXT_SEL_B]) begin
              nxt_st.pd_b = st_ff.shreg[DDAC_EXT_PD_LO +: 2];
            end
          end
        end
        default: nxt_st.ext = 1'b0;
      endcase
    end
  end

  // reset: outputs zero, 100k power-down, no drive
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_ff <= '0;
      st_ff.fsm <= DDAC_IDLE;
      st_ff.out_a <= DDAC_CODE_ZERO;
      st_ff.out_b <= DDAC_CODE_ZERO;
      st_ff.pd_a <= DDAC_PD_100K;
      st_ff.pd_b <= DDAC_PD_100K;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // open drain: only ever pull low, never touch the clock line
  assign sda_out = 1'b0;
  assign sda_oe = st_ff.drv_low;
  // output code kept through power-down, so wake-up restores it
  assign channel_a_analog_out = st_ff.out_a;
  assign channel_b_analog_out = st_ff.out_b;
  assign powerdown_sel_a = st_ff.pd_a;
  assign powerdown_sel_b = st_ff.pd_b;
  assign buf_en_a = (st_ff.pd_a == DDAC_PD_UP);
  assign buf_en_b = (st_ff.pd_b == DDAC_PD_UP);
  assign input_reg_a = st_ff.in_a;
  assign input_reg_b = st_ff.in_b;

  a_gated_quiet: assert property (@(posedge ref_clk) disable iff (srst)
    (st_ff.fsm == DDAC_GATED && !bus.start_det) |=> !sda_oe)
    else $error("drive while gated");
  a_stop_gates: assert property (@(posedge ref_clk) disable iff (srst)
    bus.stop_det |=> st_ff.fsm == DDAC_GATED) else $error("stop ignored");
  a_pd_buf_off: assert property (@(posedge ref_clk) disable iff (srst)
    st_ff.pd_a != DDAC_PD_UP |-> !buf_en_a) else $error("buffer on");
  a_in_only_hold: assert property (@(posedge ref_clk) disable iff (srst)
    (st_ff.commit && st_ff.cmd_hi[7:4] == DDAC_CMD_IN_A) |=>
    $stable(channel_a_analog_out)) else $error("output moved");
  a_no_commit_held: assert property (@(posedge ref_clk) disable iff (srst)
    !st_ff.commit |=> $stable(st_ff.in_a) && $stable(st_ff.in_b))
    else $error("input changed without commit");
  a_ack_release: assert property (@(posedge ref_clk) disable iff (srst)
    (st_ff.fsm == DDAC_WR_ACK && bus.scl_fall && !bus.stop_det &&
    !bus.start_det) |=> !sda_oe) else $error("ack held");
  a_mismatch_gate: assert property (@(posedge ref_clk) disable iff (srst)
    (st_ff.fsm == DDAC_ADDR && bus.scl_fall && st_ff.bitn == DDAC_BIT_ACK &&
    st_ff.shreg[7:1] != my_addr && !bus.start_det && !bus.stop_det) |=>
    st_ff.fsm == DDAC_GATED) else $error("mismatch not gated");
  a_addr_ack_pull: assert property (@(posedge ref_clk) disable iff (srst)
    st_ff.fsm == DDAC_ADDR_ACK |-> sda_oe)
    else $error("address ack missing");
  a_data_ack_pull: assert property (@(posedge ref_clk) disable iff (srst)
    st_ff.fsm == DDAC_WR_ACK |-> sda_oe)
    else $error("data ack missing");
  a_all_loads_out: assert property (@(posedge ref_clk) disable iff (srst)
    (st_ff.commit && st_ff.cmd_hi[7:4] == DDAC_CMD_ALL) |=>
    (channel_a_analog_out == $past(rx_code) &&
    channel_b_analog_out == $past(rx_code)))
    else $error("load all missed");
  a_pd_keeps_code: assert property (@(posedge ref_clk) disable iff (srst)
    ($changed(st_ff.pd_a)) |-> $stable(st_ff.out_a))
    else $error("code lost at power change");
endmodule
`default_nettype wire
